// >>> hdl/bsc_pkg.sv
// Constants and field layouts for the buck setpoint slew control block
package bsc_pkg;
  localparam logic [7:0] IDX_V3     = 8'h10;
  localparam logic [7:0] IDX_RAMP   = 8'h11;
  localparam logic [7:0] IDX_UNLOCK = 8'h20;
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] RST_V3     = 8'h08;
  localparam logic [7:0] RST_RAMP   = 8'h06;
  // Arbitrary neutral unlock key
  localparam logic [7:0] UNLOCK_KEY = 8'h5A;
  localparam logic [2:0] RATE_IMMED = 3'h7;
  localparam int         CLK_NS     = 10;
  localparam int         BASE_DWELL_NS = 224_000;
  localparam int         BASE_DWELL_CYC = BASE_DWELL_NS / CLK_NS;
  localparam int         CNT_W      = 16;
  localparam int         MV_W       = 12;
  localparam logic [5:0] SEG1_CODE  = 6'h18;
  localparam logic [5:0] SEG2_CODE  = 6'h35;
  localparam logic [5:0] SEG3_CODE  = 6'h38;
  localparam int         SEG0_MV    = 900;
  localparam int         SEG1_MV    = 1500;
  localparam int         SEG2_MV    = 3000;
  localparam int         MAX_MV     = 3300;
  localparam int         STEP0_MV   = 25;
  localparam int         STEP1_MV   = 50;
  localparam int         STEP2_MV   = 100;

  typedef struct packed {
    logic       ext_adjust;
    logic       reserved;
    logic [5:0] code;
  } bsc_v3_t;

  typedef struct packed {
    logic       go;
    logic       go_bypass;
    logic [2:0] force_pwm;
    logic [2:0] rate;
  } bsc_ramp_t;
endpackage : bsc_pkg

// >>> hdl/bsc_setpoint_ctrl.sv
// APB register slave and code-step ramp engine for the buck three setpoint
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module bsc_setpoint_ctrl #(
  parameter int RAMP_BASE_CYCLES = bsc_pkg::BASE_DWELL_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           external_adjust_sel_three,
  output logic                           force_pwm_one,
  output logic                           force_pwm_two,
  output logic                           force_pwm_three,
  output logic      [5:0]                active_code_three,
  output logic      [bsc_pkg::MV_W-1:0]  setpoint_mv_three,
  output logic                           ramp_busy
);
  typedef enum logic {BSC_IDLE, BSC_RAMP} bsc_state_t;

  // Local copy of the counter width so the size cast takes a plain name
  localparam int CW = bsc_pkg::CNT_W;

  bsc_pkg::bsc_v3_t            v3;
  bsc_pkg::bsc_v3_t            next_v3;
  bsc_pkg::bsc_ramp_t          ramp;
  bsc_pkg::bsc_ramp_t          next_ramp;
  bsc_state_t                  state;
  bsc_state_t                  next_state;
  logic [5:0]                  active;
  logic [5:0]                  next_active;
  logic [bsc_pkg::CNT_W-1:0]   cnt;
  logic [bsc_pkg::CNT_W-1:0]   next_cnt;
  logic                        armed;
  logic                        next_armed;
  logic [31:0]                 next_prdata;
  logic [bsc_pkg::CNT_W-1:0]   dwell;
  logic [bsc_pkg::ADDR_W-1:0]  idx;
  logic                        wr;
  logic                        hit_v3;
  logic                        hit_ramp;
  logic                        hit_unl;
  logic                        mapped;
  logic                        ok_prot;
  logic                        done;
  logic                        step;

  // Registers are word aligned: byte address is four times the index
  assign idx      = paddr[bsc_pkg::ADDR_W+1:2];
  assign hit_v3   = (idx == bsc_pkg::IDX_V3);
  assign hit_ramp = (idx == bsc_pkg::IDX_RAMP);
  assign hit_unl  = (idx == bsc_pkg::IDX_UNLOCK);
  assign mapped   = hit_v3 | hit_ramp | hit_unl;
  assign wr       = psel & penable & pwrite;
  assign ok_prot  = wr & (hit_v3 | hit_ramp) & armed & (paddr[1:0] == 2'b00);
  assign pready   = penable;
  // Locked writes and unmapped addresses report an error, no wait states
  assign pslverr  = psel & penable & (~mapped | (pwrite & (hit_v3 | hit_ramp) & ~armed));

  // Dwell halves per rate code; timing is per code, not per volt
  assign dwell = CW'(RAMP_BASE_CYCLES >> ramp.rate);
  assign done  = (state == BSC_RAMP) & (active == v3.code);
  assign step  = (state == BSC_RAMP) & ~done
               & ((ramp.rate == bsc_pkg::RATE_IMMED) | (cnt >= dwell - 1'b1));

  function automatic logic [bsc_pkg::MV_W-1:0] code_to_mv(input logic [5:0] c);
    int mv;
    mv = bsc_pkg::SEG0_MV + bsc_pkg::STEP0_MV * int'(c);
    if (c >= bsc_pkg::SEG3_CODE)
      mv = bsc_pkg::MAX_MV;
    else if (c >= bsc_pkg::SEG2_CODE)
      mv = bsc_pkg::SEG2_MV + bsc_pkg::STEP2_MV * int'(c - bsc_pkg::SEG2_CODE);
    else if (c >= bsc_pkg::SEG1_CODE)
      mv = bsc_pkg::SEG1_MV + bsc_pkg::STEP1_MV * int'(c - bsc_pkg::SEG1_CODE);
    return mv[bsc_pkg::MV_W-1:0];
  endfunction : code_to_mv

  // Register file and unlock
  always_comb
  begin
    next_v3     = v3;
    next_ramp   = ramp;
    next_armed  = armed;
    next_prdata = prdata;
    if (psel & ~penable)
    begin
      next_prdata = 32'h0000_0000;
      if (hit_v3)
        next_prdata[7:0] = {v3.ext_adjust, 1'b0, v3.code};
      else if (hit_ramp)
        next_prdata[7:0] = ramp;
    end
    if (done)
      next_ramp.go = 1'b0;
    if (wr)
      next_armed = hit_unl & (pwdata[7:0] == bsc_pkg::UNLOCK_KEY);
    if (ok_prot & hit_v3)
    begin
      next_v3.ext_adjust = pwdata[7];
      next_v3.code       = pwdata[5:0];
      next_v3.reserved   = 1'b0;
      if (ramp.go_bypass)
        next_ramp.go = 1'b1;
    end
    if (ok_prot & hit_ramp)
    begin
      next_ramp.go_bypass = pwdata[6];
      next_ramp.force_pwm = pwdata[5:3];
      next_ramp.rate      = pwdata[2:0];
      // Zero leaves go alone; a new start beats the self clear
      if (pwdata[7])
        next_ramp.go = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      v3     <= bsc_pkg::RST_V3;
      ramp   <= bsc_pkg::RST_RAMP;
      armed  <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      v3     <= next_v3;
      ramp   <= next_ramp;
      armed  <= next_armed;
      prdata <= next_prdata;
    end
  end

  // Ramp engine
  always_comb
  begin
    next_state  = state;
    next_active = active;
    next_cnt    = '0;
    case (state)
      BSC_IDLE:
      begin
        if (ramp.go)
          next_state = BSC_RAMP;
      end
      BSC_RAMP:
      begin
        if (done)
          next_state = BSC_IDLE;
        else if (ramp.rate == bsc_pkg::RATE_IMMED)
          next_active = v3.code;
        else if (step)
          next_active = (v3.code > active) ? active + 6'h01 : active - 6'h01;
        else
          next_cnt = cnt + 1'b1;
      end
      default:
        next_state = BSC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state  <= BSC_IDLE;
      active <= bsc_pkg::RST_V3[5:0];
      cnt    <= '0;
    end
    else
    begin
      state  <= next_state;
      active <= next_active;
      cnt    <= next_cnt;
    end
  end

  assign external_adjust_sel_three = v3.ext_adjust;
  assign force_pwm_one     = ramp.force_pwm[2];
  assign force_pwm_two     = ramp.force_pwm[1];
  assign force_pwm_three   = ramp.force_pwm[0];
  assign active_code_three = active;
  // The code drives the output only while external adjust is off
  assign setpoint_mv_three = v3.ext_adjust ? '0 : code_to_mv(active);
  assign ramp_busy         = ramp.go;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RSV_ZERO: assert property (
    psel & penable & ~pwrite & hit_v3 |-> prdata[6] == 1'b0)
    else $error("reserved bit read as one");
  AST_LOCKED: assert property (
    wr & (hit_v3 | hit_ramp) & ~armed |=> $stable(v3) && ($stable(ramp.rate)))
    else $error("locked write changed a register");
  AST_GO_CLEAR: assert property (
    done & ~(ok_prot & (hit_ramp & pwdata[7] | hit_v3 & ramp.go_bypass))
      |=> ~ramp.go ##1 (state == BSC_IDLE))
    else $error("go not cleared on completion");
  AST_GO_START: assert property (
    ok_prot & hit_ramp & pwdata[7] |=> ramp.go ##[1:2] state == BSC_RAMP)
    else $error("go write did not start ramp");
  AST_BYPASS: assert property (
    ok_prot & hit_v3 & ramp.go_bypass |=> ramp.go)
    else $error("bypass write did not start ramp");
  AST_PWM: assert property (
    ok_prot & hit_ramp |=> {force_pwm_one, force_pwm_two, force_pwm_three}
      == $past(pwdata[5:3]))
    else $error("force pwm bits wrong");
  AST_IMMED: assert property (
    state == BSC_RAMP & ramp.rate == bsc_pkg::RATE_IMMED & ~done
      |=> active == $past(v3.code))
    else $error("immediate rate did not jump");
  AST_ONE_STEP: assert property (
    $changed(active) & $past(ramp.rate) != bsc_pkg::RATE_IMMED
      |-> (active - $past(active) == 6'h01) || ($past(active) - active == 6'h01))
    else $error("ramp moved more than one code");
  AST_DWELL: assert property (
    $changed(active) & $past(ramp.rate) != bsc_pkg::RATE_IMMED
      |-> $past(cnt) >= $past(dwell) - 1'b1)
    else $error("code stepped before dwell elapsed");
  AST_IDLE_HOLD: assert property (
    state == BSC_IDLE |=> $stable(active))
    else $error("active code moved while idle");
  AST_DONE_IDLE: assert property (
    state == BSC_RAMP & done |=> state == BSC_IDLE)
    else $error("ramp did not end at target");
  AST_GO_HOLD: assert property (
    ramp.go & ~done |=> ramp.go)
    else $error("go dropped before completion");
  AST_GO_ZERO: assert property (
    ~ramp.go & ok_prot & hit_ramp & ~pwdata[7] |=> ~ramp.go)
    else $error("writing go zero started a ramp");
  AST_NO_BYPASS: assert property (
    ~ramp.go & ok_prot & hit_v3 & ~ramp.go_bypass |=> ~ramp.go)
    else $error("setpoint write started ramp without bypass");
  AST_EXT_MV: assert property (
    external_adjust_sel_three |-> setpoint_mv_three == '0)
    else $error("code drove output under external adjust");
  AST_TOP_CODE: assert property (
    ~external_adjust_sel_three & (active >= bsc_pkg::SEG3_CODE)
      |-> setpoint_mv_three == bsc_pkg::MAX_MV)
    else $error("top codes not at maximum");
  AST_STEP_UP: assert property (
    step & (ramp.rate != bsc_pkg::RATE_IMMED) & (v3.code > active)
      |=> active == $past(active) + 6'h01)
    else $error("ramp stepped the wrong way up");
  AST_STEP_DOWN: assert property (
    step & (ramp.rate != bsc_pkg::RATE_IMMED) & (v3.code < active)
      |=> active == $past(active) - 6'h01)
    else $error("ramp stepped the wrong way down");
  AST_ARM: assert property (
    wr |=> armed == $past(hit_unl & (pwdata[7:0] == bsc_pkg::UNLOCK_KEY)))
    else $error("unlock arm state wrong after write");
  AST_RATE_WR: assert property (
    ok_prot & hit_ramp |=> ramp.rate == $past(pwdata[2:0]))
    else $error("rate code not taken from write");
endmodule : bsc_setpoint_ctrl

// >>> verification/tb_bsc_setpoint_ctrl.sv
// Self-checking bench for the buck setpoint slew control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_bsc_setpoint_ctrl;
  typedef struct packed {logic chk; logic [31:0] data; logic err;} bsc_exp_t;
  logic                      clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                      ext3, pwm1, pwm2, pwm3, busy;
  logic [31:0]               paddr, pwdata, prdata;
  logic [5:0]                act, prev, tgt;
  logic [2:0]                rate_now;
  logic [bsc_pkg::MV_W-1:0]  mv;
  bsc_exp_t                  q[$];
  bsc_exp_t                  e_now;
  int                        n_mismatch, total_checks, cyc;

  bsc_setpoint_ctrl #(.RAMP_BASE_CYCLES(64)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_adjust_sel_three(ext3), .force_pwm_one(pwm1), .force_pwm_two(pwm2),
    .force_pwm_three(pwm3), .active_code_three(act), .setpoint_mv_three(mv),
    .ramp_busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Expected millivolts per code, worked out from the segment table
  function automatic logic [bsc_pkg::MV_W-1:0] mvof(input logic [5:0] c);
    if (c < 6'h18) return 12'(900 + 25 * c);
    if (c < 6'h35) return 12'(1500 + 50 * (c - 24));
    if (c < 6'h38) return 12'(3000 + 100 * (c - 53));
    return 12'd3300;
  endfunction : mvof

  task automatic apb(input logic wr, input logic [31:0] a, d, input logic err, chk,
                     input logic [31:0] ex);
    q.push_back('{chk, ex, err});
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so the next setup never lands in the release time step
    @(posedge clk);
  endtask : apb

  task automatic wp(input logic [31:0] a, d);
    apb(1'b1, 32'h80, 32'h5A, 1'b0, 1'b0, 32'h0);
    apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
  endtask : wp

  task automatic wait_idle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
    `CHK("busy", 1'b0, busy)
  endtask : wait_idle

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  // Result watcher: pairs each completed transfer with the oldest note
  always @(posedge clk)
  begin
    if (psel && penable && pready)
    begin
      e_now = q.pop_front();
      `CHK("pslverr", e_now.err, pslverr)
      if (e_now.chk) `CHK("prdata", e_now.data, prdata)
    end
    if (!rst && rate_now != 3'h7 && act !== prev)
      `CHK("step", 1'b1, act == prev + 6'h1 || act + 6'h1 == prev)
    prev = act;
  end

  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    rate_now = 3'h6; prev = 6'h08; n_mismatch = 0; total_checks = 0; cyc = 0;
    void'($urandom(76));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 32'h40, 32'h0, 1'b0, 1'b1, 32'h08);
    apb(1'b0, 32'h44, 32'h0, 1'b0, 1'b1, 32'h06);
    `CHK("mv rst", 12'd1100, mv)
    apb(1'b1, 32'h40, 32'h3F, 1'b1, 1'b0, 32'h0);
    apb(1'b0, 32'h40, 32'h0, 1'b0, 1'b1, 32'h08);
    apb(1'b0, 32'h08, 32'h0, 1'b1, 1'b1, 32'h0);
    wp(32'h40, 32'hFF);
    apb(1'b0, 32'h40, 32'h0, 1'b0, 1'b1, 32'hBF);
    `CHK("ext", 1'b1, ext3)
    `CHK("mv ext", 12'd0, mv)
    tgt = 6'($urandom % 64);
    wp(32'h40, {26'h0, tgt});
    wp(32'h44, 32'hB6);
    `CHK("pwm", 3'b110, {pwm1, pwm2, pwm3})
    wait_idle();
    `CHK("act", tgt, act)
    `CHK("mv", mvof(tgt), mv)
    apb(1'b0, 32'h44, 32'h0, 1'b0, 1'b1, 32'h36);
    rate_now = 3'h7;
    wp(32'h40, 32'h3F);
    wp(32'h44, 32'h8F);
    `CHK("pwm3", 3'b001, {pwm1, pwm2, pwm3})
    wait_idle();
    `CHK("act max", 6'h3F, act)
    `CHK("mv max", 12'd3300, mv)
    wp(32'h44, 32'h47);
    wp(32'h40, 32'h00);
    wait_idle();
    `CHK("act byp", 6'h00, act)
    `CHK("mv min", 12'd900, mv)
    rate_now = 3'h6;
    wp(32'h44, 32'h06);
    wp(32'h40, 32'h05);
    repeat (20) @(posedge clk);
    `CHK("no go", 6'h00, act)
    wp(32'h44, 32'h86);
    wait_idle();
    `CHK("act go", 6'h05, act)
    conclude();
  end
endmodule : tb_bsc_setpoint_ctrl
